// >>> logic/eais_regs.vh
`ifndef EAIS_REGS_VH
`define EAIS_REGS_VH

// register indices; byte address is four times the index
`define EAIS_IDX_CH0_LO      12'h0E18
`define EAIS_IDX_CH0_LO_PCT  12'h0E19
`define EAIS_IDX_CH0_MID     12'h0E1A
`define EAIS_IDX_CH0_MID_PCT 12'h0E1B
`define EAIS_IDX_CH0_HI      12'h0E1C
`define EAIS_IDX_CH0_HI_PCT  12'h0E1D
`define EAIS_IDX_CH1_LO      12'h0E1E
`define EAIS_IDX_CH1_LO_PCT  12'h0E1F
`define EAIS_IDX_CH1_MID     12'h0E20
`define EAIS_IDX_CH1_MID_PCT 12'h0E21
`define EAIS_IDX_CH1_HI      12'h0E22
`define EAIS_IDX_CH1_HI_PCT  12'h0E23
`define EAIS_IDX_TYPE0       12'h0F00
`define EAIS_IDX_TYPE1       12'h0F01
`define EAIS_IDX_EXT_SEL     12'h0F02
`define EAIS_IDX_FMAX        12'h0F03
`define EAIS_IDX_ST_PCT0     12'h0F04
`define EAIS_IDX_ST_PCT1     12'h0F05
`define EAIS_IDX_ST_FRQ0     12'h0F06
`define EAIS_IDX_ST_FRQ1     12'h0F07

// slot layout of one channel inside the breakpoint store
`define EAIS_CH_SLOTS        4'h6
`define EAIS_SLOT_LO         4'h0
`define EAIS_SLOT_LO_PCT     4'h1
`define EAIS_SLOT_MID        4'h2
`define EAIS_SLOT_MID_PCT    4'h3
`define EAIS_SLOT_HI         4'h4
`define EAIS_SLOT_HI_PCT     4'h5

// value limits in hundredths
`define EAIS_PCT_FULL        16'h2710
`define EAIS_VOLT_MAX        16'h03E8
`define EAIS_CURR_MAX        16'h07D0

// reset values
`define EAIS_RST_LO          16'h0000
`define EAIS_RST_LO_PCT      16'h0000
`define EAIS_RST_MID         16'h01F4
`define EAIS_RST_MID_PCT     16'h1388
`define EAIS_RST_HI          `EAIS_VOLT_MAX
`define EAIS_RST_HI_PCT      `EAIS_PCT_FULL
`define EAIS_RST_TYPE        16'h0000
`define EAIS_RST_EXT_SEL     16'h0003
`define EAIS_RST_FMAX        16'h1770

// extension input selection codes
`define EAIS_SEL_CH0         16'h0001
`define EAIS_SEL_CH1         16'h0002
`define EAIS_SEL_BOTH        16'h0003

// divider runs one quotient bit per clock
`define EAIS_DIV_LAST        5'h1F

`endif

// >>> logic/eais_top.v
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "eais_regs.vh"
module eais_top #(
	parameter DW = 16
) (
	// clock and reset
	input  wire          clk_i,
	input  wire          nrst_i,
	// ahb-lite slave
	input  wire          hsel_i,
	input  wire [31:0]   haddr_i,
	input  wire [1:0]    htrans_i,
	input  wire          hwrite_i,
	input  wire [2:0]    hsize_i,
	input  wire [31:0]   hwdata_i,
	input  wire          hready_i,
	output wire [31:0]   hrdata_o,
	output wire          hreadyout_o,
	output wire          hresp_o,
	// measured inputs, hundredths of a volt or milliamp
	input  wire [DW-1:0] ext_analog_in_ch0_i,
	input  wire [DW-1:0] ext_analog_in_ch1_i,
	// scaled results and channel status flags
	output wire [DW-1:0] ch0_pct_o,
	output wire [DW-1:0] ch1_pct_o,
	output wire [DW-1:0] ch0_freq_cmd_o,
	output wire [DW-1:0] ch1_freq_cmd_o,
	output wire          ch0_active_o,
	output wire          ch1_active_o,
	output wire          ch0_current_mode_o,
	output wire          ch1_current_mode_o
);

////////////////////////////////////////////////////////////////////////////////
// state codes

localparam [2:0] S_SEL   = 3'h0;
localparam [2:0] S_DIV   = 3'h1;
localparam [2:0] S_PCT   = 3'h2;
localparam [2:0] S_FRQ   = 3'h3;
localparam [2:0] S_STORE = 3'h4;

function [DW-1:0] eais_clamp;
	input [DW-1:0] v;
	input [DW-1:0] m;
	begin
		eais_clamp = (v > m) ? m : v;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// storage

reg  [DW-1:0] cfg_q [0:11];
reg  [DW-1:0] type0_q;
reg  [DW-1:0] type1_q;
reg  [DW-1:0] ext_sel_q;
reg  [DW-1:0] fmax_q;

reg  [11:0]   aidx_q;
reg           aok_q;
reg           wr_q;
reg           rd_q;
reg           hready_q;
reg  [31:0]   hrdata_q;
reg           hresp_q;

reg  [2:0]    state_q;
reg           ch_q;
reg  [31:0]   num_q;
reg  [DW-1:0] den_q;
reg  [DW:0]   rem_q;
reg  [4:0]    cnt_q;
reg           phase_q;
reg           neg_q;
reg  [DW-1:0] pa_q;
reg  [DW-1:0] pct_q;

reg  [DW-1:0] pct0_q;
reg  [DW-1:0] pct1_q;
reg  [DW-1:0] frq0_q;
reg  [DW-1:0] frq1_q;
reg           act0_q;
reg           act1_q;
reg           cur0_q;
reg           cur1_q;

integer       i;

////////////////////////////////////////////////////////////////////////////////
// bus decode

wire          a_take  = hsel_i & htrans_i[1] & hready_i;
wire          a_ok    = (haddr_i[31:14] == 18'h0_0000) & (haddr_i[1:0] == 2'h0);
wire [11:0]   woff    = aidx_q - `EAIS_IDX_CH0_LO;
wire          in_cfg  = (aidx_q >= `EAIS_IDX_CH0_LO) & (aidx_q <= `EAIS_IDX_CH1_HI_PCT);
wire          w_ch1   = (woff[3:0] >= `EAIS_CH_SLOTS);
wire [3:0]    wslot   = w_ch1 ? (woff[3:0] - `EAIS_CH_SLOTS) : woff[3:0];
wire          w_cur   = w_ch1 ? (type1_q != 16'h0000) : (type0_q != 16'h0000);
// points sit in even slots, percentages in odd ones
wire [DW-1:0] w_lim   = wslot[0] ? `EAIS_PCT_FULL :
			(w_cur ? `EAIS_CURR_MAX : `EAIS_VOLT_MAX);
wire [DW-1:0] w_val   = eais_clamp(hwdata_i[DW-1:0], w_lim);

reg  [DW-1:0] rd_mux;

always @* begin
	rd_mux = 16'h0000;
	if (!aok_q) begin
		rd_mux = 16'h0000;
	end else if (in_cfg) begin
		rd_mux = cfg_q[woff[3:0]];
	end else if (aidx_q == `EAIS_IDX_TYPE0) begin
		rd_mux = type0_q;
	end else if (aidx_q == `EAIS_IDX_TYPE1) begin
		rd_mux = type1_q;
	end else if (aidx_q == `EAIS_IDX_EXT_SEL) begin
		rd_mux = ext_sel_q;
	end else if (aidx_q == `EAIS_IDX_FMAX) begin
		rd_mux = fmax_q;
	end else if (aidx_q == `EAIS_IDX_ST_PCT0) begin
		rd_mux = pct0_q;
	end else if (aidx_q == `EAIS_IDX_ST_PCT1) begin
		rd_mux = pct1_q;
	end else if (aidx_q == `EAIS_IDX_ST_FRQ0) begin
		rd_mux = frq0_q;
	end else if (aidx_q == `EAIS_IDX_ST_FRQ1) begin
		rd_mux = frq1_q;
	end
end

////////////////////////////////////////////////////////////////////////////////
// ahb-lite slave and settings
// reads take one wait state so the read data leaves a flop and a read
// right behind a write already sees the written value

always @(posedge clk_i or negedge nrst_i) begin
	if (!nrst_i) begin
		for (i = 0; i < 2; i = i + 1) begin
			cfg_q[i*6+0] <= `EAIS_RST_LO;
			cfg_q[i*6+1] <= `EAIS_RST_LO_PCT;
			cfg_q[i*6+2] <= `EAIS_RST_MID;
			cfg_q[i*6+3] <= `EAIS_RST_MID_PCT;
			cfg_q[i*6+4] <= `EAIS_RST_HI;
			cfg_q[i*6+5] <= `EAIS_RST_HI_PCT;
		end
		type0_q   <= `EAIS_RST_TYPE;
		type1_q   <= `EAIS_RST_TYPE;
		ext_sel_q <= `EAIS_RST_EXT_SEL;
		fmax_q    <= `EAIS_RST_FMAX;
		aidx_q    <= 12'h000;
		aok_q     <= 1'b0;
		wr_q      <= 1'b0;
		rd_q      <= 1'b0;
		hready_q  <= 1'b1;
		hrdata_q  <= 32'h0000_0000;
		hresp_q   <= 1'b0;
	end else begin
		wr_q <= 1'b0;
		if (rd_q) begin
			hrdata_q <= {16'h0000, rd_mux};
			hready_q <= 1'b1;
			rd_q     <= 1'b0;
		end
		if (a_take) begin
			aidx_q <= haddr_i[13:2];
			aok_q  <= a_ok;
			wr_q   <= hwrite_i;
			if (!hwrite_i) begin
				rd_q     <= 1'b1;
				hready_q <= 1'b0;
			end
		end
		// unmapped or read-only targets drop the write silently
		if (wr_q && aok_q) begin
			if (in_cfg) begin
				cfg_q[woff[3:0]] <= w_val;
			end else if (aidx_q == `EAIS_IDX_TYPE0) begin
				type0_q <= hwdata_i[DW-1:0];
			end else if (aidx_q == `EAIS_IDX_TYPE1) begin
				type1_q <= hwdata_i[DW-1:0];
			end else if (aidx_q == `EAIS_IDX_EXT_SEL) begin
				ext_sel_q <= hwdata_i[DW-1:0];
			end else if (aidx_q == `EAIS_IDX_FMAX) begin
				fmax_q <= hwdata_i[DW-1:0];
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// segment selection for the channel in turn

wire [DW-1:0] x_in  = ch_q ? ext_analog_in_ch1_i : ext_analog_in_ch0_i;
wire [DW-1:0] p_lo  = ch_q ? cfg_q[6]  : cfg_q[0];
wire [DW-1:0] c_lo  = ch_q ? cfg_q[7]  : cfg_q[1];
wire [DW-1:0] p_mid = ch_q ? cfg_q[8]  : cfg_q[2];
wire [DW-1:0] c_mid = ch_q ? cfg_q[9]  : cfg_q[3];
wire [DW-1:0] p_hi  = ch_q ? cfg_q[10] : cfg_q[4];
wire [DW-1:0] c_hi  = ch_q ? cfg_q[11] : cfg_q[5];

wire sel0 = (ext_sel_q == `EAIS_SEL_CH0) | (ext_sel_q == `EAIS_SEL_BOTH);
wire sel1 = (ext_sel_q == `EAIS_SEL_CH1) | (ext_sel_q == `EAIS_SEL_BOTH);
wire act  = ch_q ? sel1 : sel0;

wire          lower = (x_in <= p_mid);
wire [DW-1:0] xa    = lower ? p_lo  : p_mid;
wire [DW-1:0] xb    = lower ? p_mid : p_hi;
wire [DW-1:0] pa    = lower ? c_lo  : c_mid;
wire [DW-1:0] pb    = lower ? c_mid : c_hi;
// slope sign kept apart so a falling segment needs no signed math
wire          fall  = (pb < pa);
wire [DW-1:0] dp    = fall ? (pa - pb) : (pb - pa);
wire [DW-1:0] dx    = x_in - xa;
wire [31:0]   prod  = dx * dp;
wire [31:0]   fprod = pct_q * fmax_q;

////////////////////////////////////////////////////////////////////////////////
// shared restoring divider, one bit per clock

wire [DW:0]   rem_sh  = {rem_q[DW-1:0], num_q[31]};
wire          rem_ge  = (rem_sh >= {1'b0, den_q});
wire [DW:0]   rem_sub = rem_sh - {1'b0, den_q};
// quotient can only exceed 16 bits if the breakpoint order is broken
wire [DW-1:0] quo     = (num_q[31:16] != 16'h0000) ? 16'hFFFF : num_q[DW-1:0];
wire [DW:0]   up_sum  = {1'b0, pa_q} + {1'b0, quo};
wire [DW-1:0] up_val  = up_sum[DW] ? 16'hFFFF : up_sum[DW-1:0];
wire [DW-1:0] dn_val  = (quo > pa_q) ? 16'h0000 : (pa_q - quo);

always @(posedge clk_i or negedge nrst_i) begin
	if (!nrst_i) begin
		state_q <= S_SEL;
		ch_q    <= 1'b0;
		num_q   <= 32'h0000_0000;
		den_q   <= 16'h0000;
		rem_q   <= 17'h0_0000;
		cnt_q   <= 5'h00;
		phase_q <= 1'b0;
		neg_q   <= 1'b0;
		pa_q    <= 16'h0000;
		pct_q   <= 16'h0000;
		pct0_q  <= 16'h0000;
		pct1_q  <= 16'h0000;
		frq0_q  <= 16'h0000;
		frq1_q  <= 16'h0000;
		act0_q  <= 1'b0;
		act1_q  <= 1'b0;
		cur0_q  <= 1'b0;
		cur1_q  <= 1'b0;
	end else begin
		act0_q <= sel0;
		act1_q <= sel1;
		cur0_q <= (type0_q != 16'h0000);
		cur1_q <= (type1_q != 16'h0000);
		case (state_q)
		S_SEL: begin
			if (!act || x_in <= p_lo) begin
				// inclusive compare: no dead band, so noise near lowest toggles
				pct_q   <= 16'h0000;
				state_q <= S_FRQ;
			end else if (x_in >= p_hi) begin
				pct_q   <= eais_clamp(c_hi, `EAIS_PCT_FULL);
				state_q <= S_FRQ;
			end else begin
				num_q   <= prod;
				den_q   <= xb - xa;
				rem_q   <= 17'h0_0000;
				cnt_q   <= 5'h00;
				neg_q   <= fall;
				pa_q    <= pa;
				phase_q <= 1'b0;
				state_q <= S_DIV;
			end
		end
		S_DIV: begin
			rem_q <= rem_ge ? rem_sub : rem_sh;
			num_q <= {num_q[30:0], rem_ge};
			cnt_q <= cnt_q + 5'h01;
			if (cnt_q == `EAIS_DIV_LAST) begin
				state_q <= phase_q ? S_STORE : S_PCT;
			end
		end
		S_PCT: begin
			pct_q   <= eais_clamp(neg_q ? dn_val : up_val, `EAIS_PCT_FULL);
			state_q <= S_FRQ;
		end
		S_FRQ: begin
			num_q   <= fprod;
			den_q   <= `EAIS_PCT_FULL;
			rem_q   <= 17'h0_0000;
			cnt_q   <= 5'h00;
			phase_q <= 1'b1;
			state_q <= S_DIV;
		end
		S_STORE: begin
			if (ch_q) begin
				pct1_q <= pct_q;
				frq1_q <= quo;
			end else begin
				pct0_q <= pct_q;
				frq0_q <= quo;
			end
			ch_q    <= ~ch_q;
			state_q <= S_SEL;
		end
		default: begin
			state_q <= S_SEL;
		end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// outputs

assign hrdata_o           = hrdata_q;
assign hreadyout_o        = hready_q;
assign hresp_o            = hresp_q;
assign ch0_pct_o          = pct0_q;
assign ch1_pct_o          = pct1_q;
assign ch0_freq_cmd_o     = frq0_q;
assign ch1_freq_cmd_o     = frq1_q;
assign ch0_active_o       = act0_q;
assign ch1_active_o       = act1_q;
assign ch0_current_mode_o = cur0_q;
assign ch1_current_mode_o = cur1_q;

endmodule // eais_top
`default_nettype wire

// >>> verif/eais_ain_model.sv
`timescale 1ns/10ps
`default_nettype none
module eais_ain_model (
	input  wire logic        clk_i,
	input  wire logic [15:0] lvl0_i,
	input  wire logic [15:0] lvl1_i,
	output var logic  [15:0] ch0_o,
	output var logic  [15:0] ch1_o
);
	initial begin
		ch0_o = 16'h0000;
		ch1_o = 16'h0000;
	end
	// converter result lands one clock after the level is set
	always @(posedge clk_i) begin
		ch0_o <= lvl0_i;
		ch1_o <= lvl1_i;
	end
endmodule // eais_ain_model
`default_nettype wire

// >>> verif/eais_sva.sv
`timescale 1ns/10ps
`default_nettype none
module eais_sva #(
	parameter DW = 16
) (
	// clock, reset and bus
	input wire logic          clk_i,
	input wire logic          nrst_i,
	input wire logic          hsel_i,
	input wire logic [1:0]    htrans_i,
	input wire logic          hwrite_i,
	input wire logic          hready_i,
	input wire logic [31:0]   hrdata_o,
	input wire logic          hreadyout_o,
	// scaled results and channel status flags
	input wire logic [DW-1:0] ch0_pct_o,
	input wire logic [DW-1:0] ch1_pct_o,
	input wire logic [DW-1:0] ch0_freq_cmd_o,
	input wire logic [DW-1:0] ch1_freq_cmd_o,
	input wire logic          ch0_active_o,
	input wire logic          ch1_active_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	wire take = hsel_i && htrans_i[1] && hready_i;
	////////////////////////////////////////////////////////////////////////
	a_read_wait: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read data phase not one wait state");
	a_write_nowait: assert property (take && hwrite_i |=> hreadyout_o)
		else $error("write data phase stalled");
	// read data must not drift between completed reads
	a_rdata_hold: assert property (hreadyout_o && $past(hreadyout_o) |-> $stable(hrdata_o))
		else $error("read data changed without a read");
	a_pct0_range: assert property (ch0_pct_o <= 16'h2710)
		else $error("channel 0 percent above full scale");
	a_pct1_range: assert property (ch1_pct_o <= 16'h2710)
		else $error("channel 1 percent above full scale");
	a_ch0_off: assert property ($fell(ch0_active_o) |-> ##[1:300] ch0_pct_o == 0)
		else $error("deselected channel 0 kept a result");
	a_ch1_off: assert property ($fell(ch1_active_o) |-> ##[1:300] ch1_pct_o == 0)
		else $error("deselected channel 1 kept a result");
	a_freq0_zero: assert property (ch0_pct_o == 0 |-> ch0_freq_cmd_o == 0)
		else $error("channel 0 frequency without percent");
	a_freq1_zero: assert property (ch1_pct_o == 0 |-> ch1_freq_cmd_o == 0)
		else $error("channel 1 frequency without percent");
endmodule // eais_sva

bind eais_top eais_sva #(.DW(DW)) i_eais_sva (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i),
	.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
	.hreadyout_o(hreadyout_o), .ch0_pct_o(ch0_pct_o), .ch1_pct_o(ch1_pct_o),
	.ch0_freq_cmd_o(ch0_freq_cmd_o), .ch1_freq_cmd_o(ch1_freq_cmd_o),
	.ch0_active_o(ch0_active_o), .ch1_active_o(ch1_active_o));
`default_nettype wire

// >>> verif/tb_ext_analog_input_scaler.sv
`timescale 1ns/10ps
`default_nettype none
`include "eais_regs.vh"
module tb_ext_analog_input_scaler;
	logic clk_i = 0, nrst_i = 0, hsel = 0, hwrite = 0, hrdy, hresp, act0, act1, cm0, cm1;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0]  htrans = 0;
	logic [15:0] lv0 = 0, lv1 = 0, a0, a1, p0, p1, f0, f1;
	int n_mismatch = 0, samples_checked = 0;
	int cfg0[6] = '{200, 1000, 500, 8000, 800, 2000};
	int cfg1[6] = '{0, 0, 500, 5000, 2000, 10000};
	int dflt[6] = '{0, 0, 500, 5000, 1000, 10000};
	eais_top i_eais_top (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
		.hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
		.ext_analog_in_ch0_i(a0), .ext_analog_in_ch1_i(a1), .ch0_pct_o(p0), .ch1_pct_o(p1),
		.ch0_freq_cmd_o(f0), .ch1_freq_cmd_o(f1), .ch0_active_o(act0), .ch1_active_o(act1),
		.ch0_current_mode_o(cm0), .ch1_current_mode_o(cm1));
	eais_ain_model i_eais_ain_model (.clk_i(clk_i), .lvl0_i(lv0), .lvl1_i(lv1),
		.ch0_o(a0), .ch1_o(a1));
	initial forever #5 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// entered just after a rising edge; holds each phase until hready is seen high
	task automatic bus(input logic w, input logic [11:0] i, input logic [15:0] d,
		output logic [31:0] r);
		hsel <= 1;
		haddr <= {18'h0, i, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk_i); while (hrdy !== 1'b1);
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= {16'h0000, d};
		do @(posedge clk_i); while (hrdy !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [11:0] i, input int d);
		logic [31:0] r;
		bus(1'b1, i, d[15:0], r);
	endtask
	task automatic rd(input logic [11:0] i, input int e);
		logic [31:0] r;
		bus(1'b0, i, 16'h0000, r);
		chk(r, e);
		// the slave never signals an error, even for unmapped targets
		chk(hresp, 1'b0);
	endtask
	// over two full passes of both channels, longer than the slowest a change can take
	task automatic settle();
		repeat (300) @(posedge clk_i);
	endtask
	function automatic int ep(int x, int c[6]);
		if (x <= c[0]) return 0;
		if (x >= c[4]) return c[5];
		if (x <= c[2]) return c[1] + (x - c[0]) * (c[3] - c[1]) / (c[2] - c[0]);
		return c[3] + (x - c[2]) * (c[5] - c[3]) / (c[4] - c[2]);
	endfunction
	////////////////////////////////////////////////////////////////////////
	task automatic t_defaults();
		for (int k = 0; k < 12; k++)
			rd(`EAIS_IDX_CH0_LO + k, dflt[k % 6]);
		rd(12'h0F10, 0);
		$display("test defaults done");
	endtask
	task automatic t_ch0();
		int xs[8] = '{100, 200, 201, 350, 500, 650, 800, 900};
		int e;
		for (int k = 0; k < 6; k++)
			wr(`EAIS_IDX_CH0_LO + k, cfg0[k]);
		foreach (xs[k]) begin
			lv0 <= xs[k];
			settle();
			e = ep(xs[k], cfg0);
			chk(p0, e);
			chk(f0, e * `EAIS_RST_FMAX / 10000);
			rd(`EAIS_IDX_ST_PCT0, e);
		end
		$display("test channel 0 done");
	endtask
	task automatic t_ch1();
		wr(`EAIS_IDX_TYPE1, 1);
		wr(`EAIS_IDX_CH1_HI, 2500);
		rd(`EAIS_IDX_CH1_HI, 2000);
		lv1 <= 16'd1500;
		settle();
		chk(cm1, 1'b1);
		chk(p1, ep(1500, cfg1));
		chk(f1, ep(1500, cfg1) * `EAIS_RST_FMAX / 10000);
		// a different full-scale frequency must rescale the command
		wr(`EAIS_IDX_FMAX, 3000);
		rd(`EAIS_IDX_FMAX, 3000);
		settle();
		chk(f1, ep(1500, cfg1) * 3000 / 10000);
		lv1 <= 16'd0;
		settle();
		chk(p1, 0);
		chk(f1, 0);
		lv1 <= 16'd1500;
		$display("test channel 1 done");
	endtask
	task automatic t_sel();
		for (int s = 0; s < 4; s++) begin
			wr(`EAIS_IDX_EXT_SEL, s);
			settle();
			chk(act0, s[0]);
			chk(act1, s[1]);
			chk(p0, s[0] ? ep(900, cfg0) : 0);
			chk(p1, s[1] ? ep(1500, cfg1) : 0);
		end
		$display("test selection done");
	endtask
	task automatic t_clamp0();
		wr(`EAIS_IDX_CH0_HI, 1500);
		rd(`EAIS_IDX_CH0_HI, 1000);
		wr(`EAIS_IDX_TYPE0, 5);
		settle();
		chk(cm0, 1'b1);
		// current mode widens the point limit to 20.00 mA
		wr(`EAIS_IDX_CH0_HI, 2500);
		rd(`EAIS_IDX_CH0_HI, 2000);
		$display("test channel 0 limits done");
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		test_done();
	end
	initial begin
		repeat (12) @(posedge clk_i);
		nrst_i <= 1;
		t_defaults();
		t_ch0();
		t_ch1();
		t_sel();
		t_clamp0();
		test_done();
	end
endmodule // tb_ext_analog_input_scaler
`default_nettype wire
